/* dv/field_model.sv */
// Far side of the relay controller: two emergency-stop contacts and a start button.
// Assumes the bench gives wanted contact levels and one-cycle press requests on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module field_model #(
  parameter int PRESS_CYC = 8
) (
  // Clock
  input  wire logic sys_clk,
  // Operator requests
  input  wire logic want_a,
  input  wire logic want_b,
  input  wire logic press,
  // Pins
  output logic      chan_a,
  output logic      chan_b,
  output logic      start_btn
);
  int hold = 0;

  // Contacts follow the operator a little after the edge
  assign #2 chan_a = want_a;
  assign #2 chan_b = want_b;

  // Button held for a fixed time per press, then released
  initial start_btn = 1'b0;
  always @(posedge sys_clk) begin
    #2;
    if (press) begin
      hold = PRESS_CYC;
    end
    start_btn = (hold > 0);
    if (hold > 0) begin
      hold--;
    end
  end
endmodule
`default_nettype wire

/* dv/relay_ctrl_tb.sv */
// Self-checking bench of the relay state controller with the field model.
// Assumes shortened timing parameters: 1 ms is 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module relay_ctrl_tb;
  logic       sys_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       power_ok = 1'b0;
  logic       error_in = 1'b0;
  logic       test_done = 1'b0;
  logic       test_fail = 1'b0;
  logic       cfg_wr = 1'b0;
  logic       cfg_auto = 1'b0;
  logic       cfg_sync = 1'b0;
  logic       cfg_lock = 1'b0;
  logic       want_a = 1'b0;
  logic       want_b = 1'b0;
  logic       press = 1'b0;
  wire        chan_a;
  wire        chan_b;
  wire        start_btn;
  wire        relay_on;
  wire  [2:0] state_o;
  wire        cfg_ack;
  wire        cfg_nak;
  int         err_count = 0;
  int         n_tests = 0;
  int         cyc_cnt = 0;

  always #25 sys_clk = ~sys_clk;

  relay_ctrl #(.CYC_PER_MS(4), .ON_DELAY_MS(5), .ACT_DELAY_MS(3), .SYNC_MS(10), .LOCK_MS(5))
    u_relay_ctrl (.sys_clk(sys_clk), .nrst(nrst), .power_ok(power_ok), .error_in(error_in),
    .test_done(test_done), .test_fail(test_fail), .cfg_wr(cfg_wr), .cfg_auto(cfg_auto),
    .cfg_sync(cfg_sync), .cfg_lock(cfg_lock), .chan_a(chan_a), .chan_b(chan_b),
    .start_btn(start_btn), .relay_on(relay_on), .state_o(state_o), .cfg_ack(cfg_ack),
    .cfg_nak(cfg_nak));

  field_model u_field_model (.sys_clk(sys_clk), .want_a(want_a), .want_b(want_b),
    .press(press), .chan_a(chan_a), .chan_b(chan_b), .start_btn(start_btn));

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wait_st(input logic [2:0] exp, input int max);
    int i;
    for (i = 0; i < max && state_o !== exp; i++) begin
      step(1);
    end
    check("state_o", state_o, exp);
  endtask

  task automatic push();
    press = 1'b1;
    step(1);
    press = 1'b0;
  endtask

  task automatic cfg(input logic a, input logic s, input logic l, input logic ok);
    cfg_auto = a;
    cfg_sync = s;
    cfg_lock = l;
    cfg_wr = 1'b1;
    step(1);
    cfg_wr = 1'b0;
    check("cfg_ack", {2'b00, cfg_ack}, {2'b00, ok});
    check("cfg_nak", {2'b00, cfg_nak}, {2'b00, !ok});
  endtask

  task automatic t_power_up(input logic a, input logic s, input logic l);
    cfg(a, s, l, 1'b1);
    power_ok = 1'b1;
    wait_st(3'h1, 6);
    check("relay_on", {2'b00, relay_on}, 3'h0);
    test_done = 1'b1;
    step(1);
    test_done = 1'b0;
    step(10);
    check("state_o", state_o, 3'h1);
    wait_st(3'h2, 30);
    check("relay_on", {2'b00, relay_on}, 3'h0);
    cfg(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_manual();
    want_a = 1'b1;
    want_b = 1'b1;
    step(40);
    check("state_o", state_o, 3'h2);
    push();
    step(6);
    check("state_o", state_o, 3'h2);
    wait_st(3'h3, 20);
    check("relay_on", {2'b00, relay_on}, 3'h1);
  endtask

  task automatic t_stop();
    want_b = 1'b0;
    step(5);
    check("state_o", state_o, 3'h2);
    check("relay_on", {2'b00, relay_on}, 3'h0);
    want_b = 1'b1;
    step(30);
    check("state_o", state_o, 3'h2);
    want_a = 1'b0;
    want_b = 1'b0;
    step(4);
    push();
    step(30);
    check("state_o", state_o, 3'h2);
  endtask

  task automatic t_lock();
    want_b = 1'b1;
    step(40);
    want_a = 1'b1;
    push();
    step(30);
    check("state_o", state_o, 3'h2);
    want_a = 1'b0;
    want_b = 1'b0;
    step(4);
    want_a = 1'b1;
    want_b = 1'b1;
    step(4);
    push();
    wait_st(3'h3, 30);
  endtask

  task automatic t_error();
    error_in = 1'b1;
    wait_st(3'h4, 6);
    check("relay_on", {2'b00, relay_on}, 3'h0);
    error_in = 1'b0;
    want_a = 1'b0;
    want_b = 1'b0;
    step(20);
    check("state_o", state_o, 3'h4);
    power_ok = 1'b0;
    wait_st(3'h0, 6);
  endtask

  task automatic t_sync();
    want_a = 1'b1;
    step(60);
    want_b = 1'b1;
    step(40);
    check("state_o", state_o, 3'h2);
    want_a = 1'b0;
    want_b = 1'b0;
    step(4);
    want_a = 1'b1;
    want_b = 1'b1;
    wait_st(3'h3, 30);
    check("relay_on", {2'b00, relay_on}, 3'h1);
  endtask

  // Failed self-test, then a reset in the error state
  task automatic t_fail();
    power_ok = 1'b0;
    wait_st(3'h0, 6);
    power_ok = 1'b1;
    wait_st(3'h1, 6);
    test_fail = 1'b1;
    step(1);
    test_fail = 1'b0;
    check("state_o", state_o, 3'h4);
    check("relay_on", {2'b00, relay_on}, 3'h0);
    nrst = 1'b0;
    step(1);
    check("state_o", state_o, 3'h0);
    nrst = 1'b1;
    step(1);
    check("state_o", state_o, 3'h0);
    wait_st(3'h1, 6);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    check("state_o", state_o, 3'h0);
    check("relay_on", {2'b00, relay_on}, 3'h0);
    nrst = 1'b1;
    step(1);
    t_power_up(1'b0, 1'b0, 1'b1);
    t_manual();
    t_stop();
    t_lock();
    t_error();
    t_power_up(1'b1, 1'b1, 1'b0);
    t_sync();
    t_fail();
    finish_test();
  end
endmodule
`default_nettype wire

/* rtl/chan_check.sv */
// Input checker: synchronises the two safety channels and the start button,
// times channel discrepancy for synchronisation and signal interlock.
// Assumes pins are asynchronous to sys_clk; tick is a 1 ms enable from the controller.
`timescale 1ns/1ps
`default_nettype none
module chan_check #(
  parameter int unsigned SYNC_MS = relay_pkg::SYNC_MS,
  parameter int unsigned LOCK_MS = relay_pkg::LOCK_MS
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Pins
  input  wire logic chan_a,
  input  wire logic chan_b,
  input  wire logic start_btn,
  // Conditioned signals
  chan_if.chk       chk
);
  localparam int unsigned MS_W = relay_pkg::MS_W;

  initial begin
    if (SYNC_MS >= 4095 || LOCK_MS >= 4095) begin
      $error("chan_check: window does not fit the counter");
    end
  end

  logic [2:0]      pin_w;
  logic [2:0]      meta_r;
  logic [2:0]      pin_r;
  logic            start_d_r;
  logic            both_d_r;
  logic [MS_W-1:0] one_cnt_r;
  logic            sync_ok_r;
  logic            lock_r;
  logic            both_w;
  logic            one_w;

  assign pin_w = {start_btn, chan_b, chan_a};

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          meta_r[i] <= 1'b0;
          pin_r[i]  <= 1'b0;
        end else begin
          meta_r[i] <= pin_w[i];
          pin_r[i]  <= meta_r[i];
        end
      end
    end
  endgenerate

  assign both_w = pin_r[0] & pin_r[1];
  assign one_w  = pin_r[0] ^ pin_r[1];

  // Time spent with exactly one channel active; cleared with both idle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      one_cnt_r <= '0;
    end else if (!pin_r[0] && !pin_r[1]) begin
      one_cnt_r <= '0;
    end else if (one_w && chk.tick && one_cnt_r != relay_pkg::MS_MAX) begin
      one_cnt_r <= one_cnt_r + 1'b1;
    end
  end

  // Synchronisation verdict taken as both channels become active
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_ok_r <= 1'b0;
      both_d_r  <= 1'b0;
    end else begin
      both_d_r <= both_w;
      if (!both_w) begin
        sync_ok_r <= 1'b0;
      end else if (!both_d_r) begin
        sync_ok_r <= (one_cnt_r <= MS_W'(SYNC_MS));
      end
    end
  end

  // Interlock held until both channels are idle again
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lock_r <= 1'b0;
    end else if (!pin_r[0] && !pin_r[1]) begin
      lock_r <= 1'b0;
    end else if (one_cnt_r > MS_W'(LOCK_MS)) begin
      lock_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      start_d_r <= 1'b0;
    end else begin
      start_d_r <= pin_r[2];
    end
  end

  assign chk.both_act   = both_w;
  assign chk.start_rise = pin_r[2] & ~start_d_r;
  assign chk.sync_ok    = sync_ok_r;
  assign chk.lock_cond  = lock_r;

endmodule
`default_nettype wire

/* rtl/chan_if.sv */
// Interface: conditioned channel signals from the input checker to the controller.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  logic tick;
  logic both_act;
  logic start_rise;
  logic sync_ok;
  logic lock_cond;

  modport chk (input tick, output both_act, start_rise, sync_ok, lock_cond);
  modport ctl (output tick, input both_act, start_rise, sync_ok, lock_cond);
endinterface
`default_nettype wire

/* rtl/relay_ctrl.sv */
// Operating-state controller of a two-channel safety relay module.
// Assumes self-test and configuration strobes come from sys_clk logic;
// power, error and channel pins are asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none
module relay_ctrl #(
  parameter int unsigned CYC_PER_MS   = relay_pkg::CYC_PER_MS,
  parameter int unsigned ON_DELAY_MS  = relay_pkg::ON_DELAY_MS,
  parameter int unsigned ACT_DELAY_MS = relay_pkg::ACT_DELAY_MS,
  parameter int unsigned SYNC_MS      = relay_pkg::SYNC_MS,
  parameter int unsigned LOCK_MS      = relay_pkg::LOCK_MS
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Supply and error detection
  input  wire logic       power_ok,
  input  wire logic       error_in,
  // Self-test engine
  input  wire logic       test_done,
  input  wire logic       test_fail,
  // Configuration
  input  wire logic       cfg_wr,
  input  wire logic       cfg_auto,
  input  wire logic       cfg_sync,
  input  wire logic       cfg_lock,
  // Field pins
  input  wire logic       chan_a,
  input  wire logic       chan_b,
  input  wire logic       start_btn,
  // Outputs
  output logic            relay_on,
  output logic [2:0]      state_o,
  output logic            cfg_ack,
  output logic            cfg_nak
);
  localparam int unsigned MS_W  = relay_pkg::MS_W;
  localparam int unsigned DIV_W = relay_pkg::DIV_W;

  initial begin
    if (CYC_PER_MS < 2 || CYC_PER_MS >= 65536) begin
      $error("relay_ctrl: CYC_PER_MS out of range");
    end
    if (ON_DELAY_MS >= 4095 || ACT_DELAY_MS >= 4095 || ACT_DELAY_MS < 1) begin
      $error("relay_ctrl: delay does not fit the counter");
    end
  end

  relay_pkg::op_state_t state_r;
  relay_pkg::op_state_t state_nxt;

  logic [1:0]       pwr_meta_r;
  logic [1:0]       err_meta_r;
  logic             pwr_s;
  logic             err_s;
  logic [DIV_W-1:0] div_r;
  logic             tick_r;
  logic [MS_W-1:0]  on_ms_r;
  logic [MS_W-1:0]  act_ms_r;
  logic             test_ok_r;
  logic             start_seen_r;
  logic             auto_r;
  logic             sync_en_r;
  logic             lock_en_r;
  logic             relay_r;
  logic             cfg_ack_r;
  logic             cfg_nak_r;
  logic             on_done;
  logic             start_ok;
  logic             arm_cond;
  logic             act_done;

  chan_if ch ();

  chan_check #(
    .SYNC_MS (SYNC_MS),
    .LOCK_MS (LOCK_MS)
  ) u_chk (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .chan_a    (chan_a),
    .chan_b    (chan_b),
    .start_btn (start_btn),
    .chk       (ch.chk)
  );

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwr_meta_r <= 2'h0;
      err_meta_r <= 2'h0;
    end else begin
      pwr_meta_r <= {pwr_meta_r[0], power_ok};
      err_meta_r <= {err_meta_r[0], error_in};
    end
  end
  assign pwr_s = pwr_meta_r[1];
  assign err_s = err_meta_r[1];

  // 1 ms enable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else if (div_r == DIV_W'(CYC_PER_MS - 1)) begin
      div_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 1'b1;
      tick_r <= 1'b0;
    end
  end
  assign ch.tick = tick_r;

  // Configuration latch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      auto_r    <= 1'b0;
      sync_en_r <= 1'b0;
      lock_en_r <= 1'b0;
      cfg_ack_r <= 1'b0;
      cfg_nak_r <= 1'b0;
    end else begin
      cfg_ack_r <= cfg_wr && state_r == relay_pkg::ST_OFF;
      cfg_nak_r <= cfg_wr && state_r != relay_pkg::ST_OFF;
      if (cfg_wr && state_r == relay_pkg::ST_OFF) begin
        auto_r    <= cfg_auto;
        sync_en_r <= cfg_sync;
        lock_en_r <= cfg_lock;
      end
    end
  end

  // Switch-on delay and self-test result
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      on_ms_r   <= '0;
      test_ok_r <= 1'b0;
    end else if (state_r != relay_pkg::ST_INIT) begin
      on_ms_r   <= '0;
      test_ok_r <= 1'b0;
    end else begin
      if (tick_r && !on_done) begin
        on_ms_r <= on_ms_r + 1'b1;
      end
      if (test_done && !test_fail) begin
        test_ok_r <= 1'b1;
      end
    end
  end
  assign on_done = (on_ms_r >= MS_W'(ON_DELAY_MS));

  // Start seen only after entering run-deenergized
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      start_seen_r <= 1'b0;
    end else if (state_r != relay_pkg::ST_RUN_DE) begin
      start_seen_r <= 1'b0;
    end else if (ch.start_rise) begin
      start_seen_r <= 1'b1;
    end
  end

  assign start_ok = auto_r | start_seen_r | ch.start_rise;
  assign arm_cond = start_ok && ch.both_act
                 && !(lock_en_r && ch.lock_cond)
                 && !(sync_en_r && !ch.sync_ok);

  // Activation delay, restarted whenever the condition lapses
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      act_ms_r <= '0;
    end else if (state_r != relay_pkg::ST_RUN_DE || !arm_cond) begin
      act_ms_r <= '0;
    end else if (tick_r && !act_done) begin
      act_ms_r <= act_ms_r + 1'b1;
    end
  end
  assign act_done = (act_ms_r >= MS_W'(ACT_DELAY_MS));

  always_comb begin
    state_nxt = state_r;
    if (!pwr_s) begin
      state_nxt = relay_pkg::ST_OFF;
    end else begin
      case (state_r)
        relay_pkg::ST_OFF: begin
          state_nxt = relay_pkg::ST_INIT;
        end
        relay_pkg::ST_INIT: begin
          if (err_s || test_fail) begin
            state_nxt = relay_pkg::ST_ERROR;
          end else if (test_ok_r && on_done) begin
            state_nxt = relay_pkg::ST_RUN_DE;
          end
        end
        relay_pkg::ST_RUN_DE: begin
          if (err_s) begin
            state_nxt = relay_pkg::ST_ERROR;
          end else if (act_done && arm_cond) begin
            state_nxt = relay_pkg::ST_RUN_EN;
          end
        end
        relay_pkg::ST_RUN_EN: begin
          if (err_s) begin
            state_nxt = relay_pkg::ST_ERROR;
          end else if (!ch.both_act) begin
            state_nxt = relay_pkg::ST_RUN_DE;
          end
        end
        relay_pkg::ST_ERROR: begin
          state_nxt = relay_pkg::ST_ERROR;
        end
        default: begin
          state_nxt = relay_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= relay_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Relay output follows the next state so it matches state_r exactly
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      relay_r <= 1'b0;
    end else begin
      relay_r <= (state_nxt == relay_pkg::ST_RUN_EN);
    end
  end

  assign relay_on = relay_r;
  assign state_o  = state_r;
  assign cfg_ack  = cfg_ack_r;
  assign cfg_nak  = cfg_nak_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_drop;
    state_r == relay_pkg::ST_RUN_EN && !ch.both_act && pwr_s && !err_s;
  endsequence

  safe_output_a: assert property (relay_r == (state_r == relay_pkg::ST_RUN_EN))
    else $error("relay on outside run-energized");
  init_exit_a: assert property (state_r == relay_pkg::ST_INIT
      && state_nxt == relay_pkg::ST_RUN_DE |-> test_ok_r && on_ms_r == MS_W'(ON_DELAY_MS))
    else $error("init left early");
  power_up_a: assert property (state_r == relay_pkg::ST_OFF && pwr_s
      |=> state_r == relay_pkg::ST_INIT && !relay_r)
    else $error("no init after power");
  cfg_ignore_a: assert property (cfg_wr && state_r != relay_pkg::ST_OFF
      |=> $stable(auto_r) && $stable(sync_en_r) && $stable(lock_en_r) && cfg_nak)
    else $error("config taken outside off");
  input_drop_a: assert property (s_drop |=> !relay_r ##0 state_r == relay_pkg::ST_RUN_DE)
    else $error("outputs not dropped");
  energize_a: assert property ($rose(state_r == relay_pkg::ST_RUN_EN)
      |-> $past(act_ms_r) == MS_W'(ACT_DELAY_MS) && $past(start_ok))
    else $error("energized without delay");
  lock_block_a: assert property (state_r == relay_pkg::ST_RUN_DE && lock_en_r
      && ch.lock_cond |=> state_r != relay_pkg::ST_RUN_EN)
    else $error("interlock ignored");
  sync_block_a: assert property (state_r == relay_pkg::ST_RUN_DE && sync_en_r
      && !ch.sync_ok |=> !relay_r)
    else $error("sync ignored");
  error_enter_a: assert property (pwr_s && err_s && state_r != relay_pkg::ST_OFF
      |=> state_r == relay_pkg::ST_ERROR)
    else $error("error not entered");
  error_hold_a: assert property (state_r == relay_pkg::ST_ERROR && pwr_s
      |=> state_r == relay_pkg::ST_ERROR && !relay_r)
    else $error("error state left");
  power_off_a: assert property (!pwr_s |=> state_r == relay_pkg::ST_OFF)
    else $error("power loss ignored");
  no_start_a: assert property (state_r == relay_pkg::ST_RUN_DE && !auto_r
      && !start_seen_r && !ch.start_rise |=> state_r != relay_pkg::ST_RUN_EN)
    else $error("energized without start");

endmodule
`default_nettype wire

/* rtl/relay_pkg.sv */
// Package: states, timing figures and derived counts of the relay controller.
// Assumes a single 20 MHz system clock and a 1 ms enable tick.
package relay_pkg;

  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_INIT   = 3'h1,
    ST_RUN_DE = 3'h2,
    ST_RUN_EN = 3'h3,
    ST_ERROR  = 3'h4
  } op_state_t;

  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // Times in ms, counted in 1 ms ticks
  localparam int unsigned ON_DELAY_MS  = 2500;
  localparam int unsigned ACT_DELAY_MS = 100;
  localparam int unsigned RESPONSE_MS  = 20;
  localparam int unsigned LOCK_MS      = 200;
  localparam int unsigned SYNC_MS      = 500;

  localparam int unsigned MS_W     = 12;
  localparam int unsigned DIV_W    = 16;
  localparam logic [MS_W-1:0] MS_MAX = 12'hFFF;

endpackage
